//--- rtl/flag_connector_regs.vh
// Offsets, field positions and reset values for the
// flag and connector block. Assumes inclusion by bare name.
`ifndef FLAG_CONNECTOR_REGS_VH
`define FLAG_CONNECTOR_REGS_VH

// Register byte offsets
`define REG_CTRL          12'h000
`define REG_STATUS        12'h004
`define REG_DFLAG_WR      12'h008
`define REG_DFLAG_RD      12'h00C
`define REG_SHIFT         12'h010
`define REG_KEYS          12'h014
`define REG_GATE_CFG      12'h018
`define REG_GATE_IN       12'h01C
`define REG_AFLAG_WR_BASE 12'h020
`define REG_AFLAG_RD_BASE 12'h040
`define REG_AOUT_SEL_BASE 12'h060
`define REG_AOUT_RD_BASE  12'h068

// Control fields
`define CTRL_RUN          0
`define CTRL_CYCLE        1
`define CTRL_MSG_ACTIVE   2
`define CTRL_CHARSET_USED 3
`define CTRL_CHARSET_CFG  4

// Status fields
`define STAT_FIRST        0
`define STAT_CHARSET      1
`define STAT_GATE_OUT     2
`define STAT_RUN          3

// Analog out source codes
`define AOUT_SRC_FUNC     2'h0
`define AOUT_SRC_AFLAG    2'h1
`define AOUT_SRC_AOUT     2'h2

// Flag positions in the digital flag vector (zero based)
`define FLAG_FIRST_CYCLE  7
`define FLAG_DISP_LIGHT   24
`define FLAG_PANEL_LIGHT  25
`define FLAG_CHARSET      26

`define CTRL_RESET        32'h0000_0000

`endif

//--- rtl/basic_and_gate.v
// Four-input AND of the basic gate list with per-input inversion.
// Assumes open and inversion masks are held stable by the caller.
module basic_and_gate
#(
   parameter N_IN = 4
)
(
   input  wire [N_IN-1:0] in_level,
   input  wire [N_IN-1:0] in_invert,
   input  wire [N_IN-1:0] in_open,
   output wire            and_out
);

   wire [N_IN-1:0] eff;

   genvar g;
   generate
      for (g = 0; g < N_IN; g = g + 1)
      begin : g_in
         assign eff[g] = in_open[g] ? 1'b1 : (in_level[g] ^ in_invert[g]);
      end
   endgenerate

   assign and_out = &eff;

endmodule // basic_and_gate

//--- rtl/key_sync.v
// Two-stage synchroniser for a group of key pins.
// Assumes pins are asynchronous to the clock.
module key_sync
#(
   parameter W = 8
)
(
   input  wire         clk,
   input  wire         rst_b,
   input  wire         ce,
   input  wire [W-1:0] pin,
   output reg  [W-1:0] level
);

   reg [W-1:0] meta;

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta  <= {W{1'b0}};
         level <= {W{1'b0}};
      end
      else if (ce)
      begin
         meta  <= pin;
         level <= meta;
      end
   end

endmodule // key_sync

//--- rtl/flag_connector_logic.v
// Flag, connector and basic gate logic paced by a program-cycle strobe.
// Assumes an APB master on CORE_CLK and asynchronous key pins.
//
// Functional notes
// - Twenty-seven digital, six analog flags.
// - Startup flag high in first cycle.
// - Startup flag ordinary flag afterwards.
// - Two flags switch two backlights.
// - Charset flag selects message text set.
// - Unused charset flag uses configured set.
// - Flag outputs show previous cycle value.
// - Shift bits read-only except shift function.
// - Four cursor keys as program inputs.
// - Cursor keys usable in run, messages.
// - Panel and base cursor keys merged.
// - Four panel keys sampled in run.
// - Constant one and zero sources.
// - Basic gate inputs individually invertible.
// - Unused connectors markable as open.
// - AND gives one only all ones.
// - Open AND input reads one.
//
// Design decisions made here: the register addresses and the APB register port.
`include "flag_connector_regs.vh"

module flag_connector_logic
#(
   parameter N_DFLAG = 27,
   parameter N_AFLAG = 6,
   parameter AW      = 16,
   parameter N_AOUT  = 2,
   parameter N_SHIFT = 8
)
(
   // Clock and reset
   input  wire                  CORE_CLK,
   input  wire                  RST_B,
   input  wire                  CLK_EN,
   // APB slave
   input  wire                  PSEL,
   input  wire                  PENABLE,
   input  wire                  PWRITE,
   input  wire [11:0]           PADDR,
   input  wire [31:0]           PWDATA,
   output reg  [31:0]           PRDATA,
   output wire                  PREADY,
   output wire                  PSLVERR,
   // Shift register function
   input  wire                  SHIFT_WE,
   input  wire [N_SHIFT-1:0]    SHIFT_DATA,
   // Analog function result
   input  wire [AW-1:0]         FUNC_ANALOG,
   // Key pins
   input  wire [3:0]            BASE_CURSOR,
   input  wire [3:0]            PANEL_CURSOR,
   input  wire [3:0]            PANEL_KEYS,
   // Program-side outputs
   output reg  [N_DFLAG-1:0]    DFLAG_OUT,
   output wire [N_AFLAG*AW-1:0] AFLAG_OUT,
   output wire [N_AOUT*AW-1:0]  AOUT,
   output wire [3:0]            CURSOR_KEYS,
   output wire [3:0]            FUNC_KEYS,
   output wire                  CONST_ONE_LEVEL,
   output wire                  CONST_ZERO_LEVEL,
   output reg                   GATE_OUT,
   output wire                  DISPLAY_LIGHT,
   output wire                  PANEL_LIGHT,
   output wire                  CHARSET_SET
);

   // Address decode shared by read and write paths
   function [4:0] dec;
      input [11:0] a;
      begin
         if (a == `REG_CTRL)
            dec = 5'h01;
         else if (a == `REG_STATUS)
            dec = 5'h02;
         else if (a == `REG_DFLAG_WR)
            dec = 5'h03;
         else if (a == `REG_DFLAG_RD)
            dec = 5'h04;
         else if (a == `REG_SHIFT)
            dec = 5'h05;
         else if (a == `REG_KEYS)
            dec = 5'h06;
         else if (a == `REG_GATE_CFG)
            dec = 5'h07;
         else if (a == `REG_GATE_IN)
            dec = 5'h08;
         else if (a >= `REG_AFLAG_WR_BASE && a < `REG_AFLAG_WR_BASE + 12'h018
                  && a[1:0] == 2'h0)
            dec = 5'h09;
         else if (a >= `REG_AFLAG_RD_BASE && a < `REG_AFLAG_RD_BASE + 12'h018
                  && a[1:0] == 2'h0)
            dec = 5'h0A;
         else if (a >= `REG_AOUT_SEL_BASE && a < `REG_AOUT_SEL_BASE + 12'h008
                  && a[1:0] == 2'h0)
            dec = 5'h0B;
         else if (a >= `REG_AOUT_RD_BASE && a < `REG_AOUT_RD_BASE + 12'h008
                  && a[1:0] == 2'h0)
            dec = 5'h0C;
         else
            dec = 5'h00;
      end
   endfunction

   function src_ok;
      input [1:0] c;
      begin
         src_ok = (c == `AOUT_SRC_FUNC) || (c == `AOUT_SRC_AFLAG) ||
                  (c == `AOUT_SRC_AOUT);
      end
   endfunction

   wire        acc     = PSEL && PENABLE && CLK_EN;
   wire [4:0]  sel     = dec(PADDR);
   wire        wr      = acc && PWRITE;
   wire [2:0]  idx_a   = PADDR[4:2];
   wire        idx_o   = PADDR[2];

   assign PREADY  = 1'b1;
   assign PSLVERR = acc && (sel == 5'h00);

   reg  [31:0]          ctrl;
   reg  [N_DFLAG-1:0]   dflag_in;
   reg  [N_SHIFT-1:0]   shift_bits;
   reg  [11:0]          gate_cfg;
   reg  [3:0]           gate_in;
   reg                  first_cycle;
   reg  [AW-1:0]        aflag_in  [0:N_AFLAG-1];
   reg  [AW-1:0]        aflag_q   [0:N_AFLAG-1];
   reg  [1:0]           aout_src  [0:N_AOUT-1];
   reg  [2:0]           aout_idx  [0:N_AOUT-1];
   reg  [AW-1:0]        aout_q    [0:N_AOUT-1];
   reg                  cycle_d;

   wire run        = ctrl[`CTRL_RUN];
   wire cyc_tick   = ctrl[`CTRL_CYCLE] && !cycle_d;

   // Key synchronisers
   wire [3:0] base_cur_s;
   wire [3:0] panel_cur_s;
   wire [3:0] panel_key_s;

   key_sync #(.W(12)) u_keys
   (
      .clk   (CORE_CLK),
      .rst_b (RST_B),
      .ce    (CLK_EN),
      .pin   ({PANEL_KEYS, PANEL_CURSOR, BASE_CURSOR}),
      .level ({panel_key_s, panel_cur_s, base_cur_s})
   );

   // cursor keys live in run or message
   wire keys_live = run || ctrl[`CTRL_MSG_ACTIVE];
   assign CURSOR_KEYS = keys_live ? (base_cur_s | panel_cur_s) : 4'h0;
   assign FUNC_KEYS   = run ? panel_key_s : 4'h0;

   assign CONST_ONE_LEVEL  = 1'b1;
   assign CONST_ZERO_LEVEL = 1'b0;

   // Gate config: [3:0] invert, [7:4] open, [11:8] select key sources
   wire [3:0] gate_src;
   genvar s;
   generate
      for (s = 0; s < 4; s = s + 1)
      begin : g_src
         assign gate_src[s] = gate_cfg[8+s] ? CURSOR_KEYS[s] : gate_in[s];
      end
   endgenerate

   wire and_comb;
   basic_and_gate #(.N_IN(4)) u_and
   (
      .in_level  (gate_src),
      .in_invert (gate_cfg[3:0]),
      .in_open   (gate_cfg[7:4]),
      .and_out   (and_comb)
   );

   // Register writes
   integer i;
   always @(posedge CORE_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         ctrl        <= `CTRL_RESET;
         dflag_in    <= {N_DFLAG{1'b0}};
         shift_bits  <= {N_SHIFT{1'b0}};
         gate_cfg    <= 12'h000;
         gate_in     <= 4'h0;
         for (i = 0; i < N_AFLAG; i = i + 1)
            aflag_in[i] <= {AW{1'b0}};
         for (i = 0; i < N_AOUT; i = i + 1)
         begin
            aout_src[i] <= `AOUT_SRC_FUNC;
            aout_idx[i] <= 3'h0;
         end
      end
      else if (CLK_EN)
      begin
         if (wr && sel == 5'h01)
            ctrl <= PWDATA;
         if (wr && sel == 5'h03)
            dflag_in <= PWDATA[N_DFLAG-1:0];
         if (wr && sel == 5'h07)
            gate_cfg <= PWDATA[11:0];
         if (wr && sel == 5'h08)
            gate_in <= PWDATA[3:0];
         if (wr && sel == 5'h09 && idx_a < N_AFLAG)
            aflag_in[idx_a] <= PWDATA[AW-1:0];
         if (wr && sel == 5'h0B && src_ok(PWDATA[1:0]))
         begin
            aout_src[idx_o] <= PWDATA[1:0];
            aout_idx[idx_o] <= PWDATA[6:4];
         end
         if (SHIFT_WE)
            shift_bits <= SHIFT_DATA;
      end
   end

   // Digital flags step once per program cycle
   always @(posedge CORE_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         DFLAG_OUT   <= {N_DFLAG{1'b0}};
         GATE_OUT    <= 1'b0;
         first_cycle <= 1'b1;
         cycle_d     <= 1'b0;
      end
      else if (CLK_EN)
      begin
         cycle_d <= ctrl[`CTRL_CYCLE];
         if (cyc_tick)
         begin
            DFLAG_OUT <= dflag_in;
            DFLAG_OUT[`FLAG_FIRST_CYCLE] <= first_cycle |
                                           dflag_in[`FLAG_FIRST_CYCLE];
            first_cycle <= 1'b0;
            GATE_OUT <= and_comb;
         end
      end
   end

   // Analog flags and outputs take the same strobe
   integer j;
   always @(posedge CORE_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         for (j = 0; j < N_AFLAG; j = j + 1)
            aflag_q[j] <= {AW{1'b0}};
         for (j = 0; j < N_AOUT; j = j + 1)
            aout_q[j] <= {AW{1'b0}};
      end
      else if (CLK_EN && cyc_tick)
      begin
         for (j = 0; j < N_AFLAG; j = j + 1)
            aflag_q[j] <= aflag_in[j];
         for (j = 0; j < N_AOUT; j = j + 1)
         begin
            if (aout_src[j] == `AOUT_SRC_AFLAG)
               aout_q[j] <= aflag_q[aout_idx[j] < N_AFLAG ?
                                    aout_idx[j] : 3'h0];
            else if (aout_src[j] == `AOUT_SRC_AOUT)
               aout_q[j] <= aout_q[aout_idx[j][0]];
            else
               aout_q[j] <= FUNC_ANALOG;
         end
      end
   end

   genvar k;
   generate
      for (k = 0; k < N_AFLAG; k = k + 1)
      begin : g_af
         assign AFLAG_OUT[k*AW +: AW] = aflag_q[k];
      end
      for (k = 0; k < N_AOUT; k = k + 1)
      begin : g_ao
         assign AOUT[k*AW +: AW] = aout_q[k];
      end
   endgenerate

   assign DISPLAY_LIGHT = DFLAG_OUT[`FLAG_DISP_LIGHT];
   assign PANEL_LIGHT   = DFLAG_OUT[`FLAG_PANEL_LIGHT];
   // unused flag falls back to config
   assign CHARSET_SET = ctrl[`CTRL_CHARSET_USED] ?
                        DFLAG_OUT[`FLAG_CHARSET] : ctrl[`CTRL_CHARSET_CFG];

   // Read mux
   always @*
   begin
      PRDATA = 32'h0000_0000;
      if (sel == 5'h01)
         PRDATA = ctrl;
      else if (sel == 5'h02)
      begin
         PRDATA[`STAT_FIRST]    = first_cycle;
         PRDATA[`STAT_CHARSET]  = CHARSET_SET;
         PRDATA[`STAT_GATE_OUT] = GATE_OUT;
         PRDATA[`STAT_RUN]      = run;
      end
      else if (sel == 5'h03)
         PRDATA[N_DFLAG-1:0] = dflag_in;
      else if (sel == 5'h04)
         PRDATA[N_DFLAG-1:0] = DFLAG_OUT;
      else if (sel == 5'h05)
         PRDATA[N_SHIFT-1:0] = shift_bits;
      else if (sel == 5'h06)
         PRDATA[7:0] = {FUNC_KEYS, CURSOR_KEYS};
      else if (sel == 5'h07)
         PRDATA[11:0] = gate_cfg;
      else if (sel == 5'h08)
         PRDATA[3:0] = gate_in;
      else if (sel == 5'h09 && idx_a < N_AFLAG)
         PRDATA[AW-1:0] = aflag_in[idx_a];
      else if (sel == 5'h0A && idx_a < N_AFLAG)
         PRDATA[AW-1:0] = aflag_q[idx_a];
      else if (sel == 5'h0B)
         PRDATA[6:0] = {aout_idx[idx_o], 2'h0, aout_src[idx_o]};
      else if (sel == 5'h0C)
         PRDATA[AW-1:0] = aout_q[idx_o];
   end

endmodule // flag_connector_logic

//--- dv/flag_connector_props.sv
// Checker for the flag and connector block.
// Assumes binding to its top module; one clock domain.
module flag_connector_props
#(
   parameter N_DFLAG = 27,
   parameter N_AFLAG = 6,
   parameter AW      = 16
)
(
   // Clock, reset, bus
   input wire                  CORE_CLK,
   input wire                  RST_B,
   input wire                  CLK_EN,
   input wire                  PSEL,
   input wire                  PENABLE,
   input wire                  PWRITE,
   input wire [11:0]           PADDR,
   input wire [31:0]           PWDATA,
   input wire                  PSLVERR,
   // Keys
   input wire [3:0]            BASE_CURSOR,
   input wire [3:0]            PANEL_CURSOR,
   input wire [3:0]            CURSOR_KEYS,
   input wire [3:0]            FUNC_KEYS,
   // Program side
   input wire [N_DFLAG-1:0]    DFLAG_OUT,
   input wire [N_AFLAG*AW-1:0] AFLAG_OUT,
   input wire                  GATE_OUT,
   input wire                  CONST_ONE_LEVEL,
   input wire                  CONST_ZERO_LEVEL,
   input wire                  DISPLAY_LIGHT,
   input wire                  PANEL_LIGHT,
   input wire                  CHARSET_SET
);
   logic [4:0] ctrl_c;
   logic       tick_d;
   wire        wr0 = PSEL && PENABLE && PWRITE && CLK_EN && PADDR == 12'h000;
   wire        tick = wr0 && PWDATA[1] && !ctrl_c[1];
   // Mirror of the control word
   // Outputs move one edge after the strobe write is taken
   always_ff @(posedge CORE_CLK or negedge RST_B)
      if (!RST_B)
      begin
         ctrl_c <= 5'h00;
         tick_d <= 1'b0;
      end
      else if (CLK_EN)
      begin
         tick_d <= tick;
         if (wr0)
            ctrl_c <= PWDATA[4:0];
      end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);
   property p_const; CONST_ONE_LEVEL && !CONST_ZERO_LEVEL; endproperty
   property p_disp; DISPLAY_LIGHT == DFLAG_OUT[24]; endproperty
   property p_panel; PANEL_LIGHT == DFLAG_OUT[25]; endproperty
   property p_hold; !tick_d |=> $stable(DFLAG_OUT); endproperty
   property p_ahold; !tick_d |=> $stable(AFLAG_OUT); endproperty
   property p_ghold; !tick_d |=> $stable(GATE_OUT); endproperty
   property p_cfg; !ctrl_c[3] |-> CHARSET_SET == ctrl_c[4]; endproperty
   property p_used; ctrl_c[3] |-> CHARSET_SET == DFLAG_OUT[26]; endproperty
   property p_cur; !ctrl_c[0] && !ctrl_c[2] |-> CURSOR_KEYS == 4'h0;
   endproperty
   property p_fk; !ctrl_c[0] |-> FUNC_KEYS == 4'h0; endproperty
   property p_merge;
      ctrl_c[0] |-> CURSOR_KEYS ==
         ($past(BASE_CURSOR, 2) | $past(PANEL_CURSOR, 2));
   endproperty
   a_const: assert property (p_const) else $error("bad level");
   a_disp: assert property (p_disp) else $error("bad light");
   a_panel: assert property (p_panel) else $error("bad light");
   a_hold: assert property (p_hold) else $error("flag moved");
   a_ahold: assert property (p_ahold) else $error("aflag moved");
   a_ghold: assert property (p_ghold) else $error("gate moved");
   a_cfg: assert property (p_cfg) else $error("bad set");
   a_used: assert property (p_used) else $error("bad set");
   a_cur: assert property (p_cur) else $error("cursor leak");
   a_fk: assert property (p_fk) else $error("fkey leak");
   a_merge: assert property (p_merge) else $error("bad merge");
   c_tick: cover property (tick);
   c_gate: cover property ($rose(GATE_OUT));
   c_err: cover property (PSLVERR);
endmodule // flag_connector_props
bind flag_connector_logic flag_connector_props
   #(.N_DFLAG(N_DFLAG), .N_AFLAG(N_AFLAG), .AW(AW)) flag_connector_props_i
   (.CORE_CLK, .RST_B, .CLK_EN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PSLVERR, .BASE_CURSOR, .PANEL_CURSOR, .CURSOR_KEYS, .FUNC_KEYS,
    .DFLAG_OUT, .AFLAG_OUT, .GATE_OUT, .CONST_ONE_LEVEL, .CONST_ZERO_LEVEL,
    .DISPLAY_LIGHT, .PANEL_LIGHT, .CHARSET_SET);

//--- dv/flag_partner.sv
// Operator keys and program-side sources facing the block.
// Assumes requests from the bench; applies them after each edge.
module flag_partner
(
   input  wire         clk,
   input  wire  [11:0] key_req,
   input  wire  [8:0]  shift_req,
   input  wire  [15:0] analog_req,
   output logic [3:0]  base_cursor = 4'h0,
   output logic [3:0]  panel_cursor = 4'h0,
   output logic [3:0]  panel_keys = 4'h0,
   output logic        shift_we = 1'b0,
   output logic [7:0]  shift_data = 8'h00,
   output logic [15:0] func_analog = 16'h0000
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge clk)
   begin
      {panel_keys, panel_cursor, base_cursor} <= key_req;
      {shift_we, shift_data} <= shift_req;
      func_analog <= analog_req;
   end
endmodule // flag_partner

//--- dv/flag_connector_logic_bench.sv
// Self-checking bench for the flag and connector block.
// Assumes the partner model drives keys and program sources.
`include "flag_connector_regs.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   fail_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
   end end
module flag_connector_logic_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pw = 1'b0;
   logic [11:0] pa = 12'h000;
   logic [31:0] pd = 32'h0;
   logic [11:0] kr = 12'h000;
   logic [8:0]  sr = 9'h000;
   logic [15:0] ar = 16'h0000;
   logic [31:0] rd;
   logic        er;
   logic [26:0] prev;
   int          fail_count = 0;
   int          cmp_count = 0;
   wire [31:0]  prd;
   wire [31:0]  ao;
   wire [95:0]  afo;
   wire [26:0]  dfo;
   wire [15:0]  fa;
   wire [7:0]   sd;
   wire [3:0]   bc, pc, pk, ck, fk;
   wire         prdy, perr, swe, c1, c0, gout, dl, pl, cs;
   logic [26:0] pv [2] = '{27'h5A5A5A5, 27'h2A5A5A5};
   // Fields: open and inversion masks, levels, expected result
   logic [12:0] gt [6] = '{13'h1E1, 13'h0B5, 13'h0AA, 13'h1E01, 13'h619,
                           13'h610};
   flag_connector_logic flag_connector_logic_i
   (
      .CORE_CLK(clk), .RST_B(rst_b), .CLK_EN(1'b1), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pw), .PADDR(pa), .PWDATA(pd), .PRDATA(prd),
      .PREADY(prdy), .PSLVERR(perr), .SHIFT_WE(swe), .SHIFT_DATA(sd),
      .FUNC_ANALOG(fa), .BASE_CURSOR(bc), .PANEL_CURSOR(pc),
      .PANEL_KEYS(pk), .DFLAG_OUT(dfo), .AFLAG_OUT(afo), .AOUT(ao),
      .CURSOR_KEYS(ck), .FUNC_KEYS(fk), .CONST_ONE_LEVEL(c1),
      .CONST_ZERO_LEVEL(c0), .GATE_OUT(gout), .DISPLAY_LIGHT(dl),
      .PANEL_LIGHT(pl), .CHARSET_SET(cs)
   );
   flag_partner flag_partner_i
   (
      .clk(clk), .key_req(kr), .shift_req(sr), .analog_req(ar),
      .base_cursor(bc), .panel_cursor(pc), .panel_keys(pk),
      .shift_we(swe), .shift_data(sd), .func_analog(fa)
   );
   always #12.5 clk = ~clk;
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, pen, pw, pa, pd} <= {2'b10, w, a, d};
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      rd = prd;
      er = perr;
      {psel, pen} <= 2'b00;
      #1;
   endtask
   task tick(input logic [31:0] c);
      apb(1'b1, `REG_CTRL, c | 32'h2);
      apb(1'b1, `REG_CTRL, c);
   endtask
   task t_first;
      apb(1'b0, `REG_STATUS, 32'h0);
      `CHK("status", 1'b1, rd[0])
      tick(32'h1);
      `CHK("first", 1'b1, dfo[7])
      tick(32'h1);
      `CHK("first clr", 1'b0, dfo[7])
      apb(1'b1, `REG_DFLAG_WR, 32'h80);
      tick(32'h1);
      `CHK("first set", 1'b1, dfo[7])
      prev = 27'h80;
      foreach (pv[i])
      begin
         apb(1'b1, `REG_DFLAG_WR, {5'h0, pv[i]});
         `CHK("hold", prev, dfo)
         tick(32'h1);
         `CHK("dflag", pv[i], dfo)
         `CHK("disp", pv[i][24], dl)
         `CHK("panel", pv[i][25], pl)
         prev = pv[i];
      end
      $display("test flags done");
   endtask
   task t_charset;
      apb(1'b1, `REG_CTRL, 32'h11);
      `CHK("cfg1", 1'b1, cs)
      apb(1'b1, `REG_CTRL, 32'h01);
      `CHK("cfg0", 1'b0, cs)
      apb(1'b1, `REG_CTRL, 32'h19);
      `CHK("used0", 1'b0, cs)
      apb(1'b1, `REG_DFLAG_WR, 32'h4000000);
      tick(32'h19);
      `CHK("used1", 1'b1, cs)
      $display("test charset done");
   endtask
   task t_analog;
      ar <= 16'hBEEF;
      apb(1'b1, `REG_AFLAG_WR_BASE + 12'h014, 32'h1234);
      `CHK("ahold", 16'h0000, afo[95:80])
      tick(32'h1);
      `CHK("aflag", 16'h1234, afo[95:80])
      apb(1'b1, `REG_AOUT_SEL_BASE, 32'h51);
      apb(1'b1, `REG_AOUT_SEL_BASE + 12'h004, 32'h0);
      tick(32'h1);
      `CHK("aout0", 16'h1234, ao[15:0])
      `CHK("aout1", 16'hBEEF, ao[31:16])
      apb(1'b1, `REG_AOUT_SEL_BASE + 12'h004, 32'h02);
      tick(32'h1);
      `CHK("chain", 16'h1234, ao[31:16])
      apb(1'b0, 12'h0FC, 32'h0);
      `CHK("unmapped", 1'b1, er)
      $display("test analog done");
   endtask
   task t_shift;
      sr <= 9'h1A5;
      @(posedge clk);
      sr <= 9'h000;
      apb(1'b1, `REG_SHIFT, 32'hFF);
      apb(1'b0, `REG_SHIFT, 32'h0);
      `CHK("shift", 8'hA5, rd[7:0])
      $display("test shift done");
   endtask
   task t_keys;
      kr <= 12'h341;
      apb(1'b1, `REG_CTRL, 32'h0);
      `CHK("cur idle", 4'h0, ck)
      `CHK("fk idle", 4'h0, fk)
      apb(1'b1, `REG_CTRL, 32'h1);
      `CHK("cur run", 4'h5, ck)
      `CHK("fk run", 4'h3, fk)
      apb(1'b1, `REG_CTRL, 32'h4);
      `CHK("cur msg", 4'h5, ck)
      `CHK("fk msg", 4'h0, fk)
      $display("test keys done");
   endtask
   task t_gate;
      `CHK("one", 1'b1, c1)
      `CHK("zero", 1'b0, c0)
      for (int v = 0; v < 16; v++)
      begin
         apb(1'b1, `REG_GATE_IN, v);
         tick(32'h1);
         `CHK("and", v == 15, gout)
      end
      foreach (gt[i])
      begin
         apb(1'b1, `REG_GATE_CFG, {24'h0, gt[i][12:5]});
         apb(1'b1, `REG_GATE_IN, {28'h0, gt[i][4:1]});
         tick(32'h1);
         `CHK("inv open", gt[i][0], gout)
      end
      // Cursor keys 0101 feed the gate, inverted by 1010
      apb(1'b1, `REG_GATE_CFG, 32'hF0A);
      tick(32'h1);
      `CHK("key src", 1'b1, gout)
      $display("test gate done");
   endtask
   task end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      t_first;
      t_charset;
      t_analog;
      t_shift;
      t_keys;
      t_gate;
      end_of_test;
   end
   initial
   begin
      #500000;
      fail_count++;
      end_of_test;
   end
endmodule // flag_connector_logic_bench
